//--- rtl/csp_serial_port.sv
/*
 * Codec serial port: primary and secondary frames, register programming,
 * direct configuration input and continuous transfer, with an AXI4-Lite slave.
 * Assumes all link pins are asynchronous to aclk and slower than aclk / 4.
 */
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
// How it works
// - Secondary words sampled on falling bit clock
// - Zero upper byte is a no-operation
// - Read bit returns register on dout
// - Read-mode register refuses writes until rewritten
// - Read data in low byte, same frame
// - Write answer carries only device address
// - Request pulse sets flag, cleared after programming
// - Secondary frame at half the primary interval
// - Interval 256 or 512 bit clocks by cascade
// - All words most significant bit first
// - 15-bit mode uses D0 as request
// - Reset default is 15-bit mode
// - Converter samples are two's complement
// - 16-bit mode takes only hardware requests
// - Direct input sampled on falling bit clock
// - Continuous mode needs solo master, select 00
// - Continuous words back to back, early sync
// - Continuous mode ignores secondary requests
`timescale 1ns/10ps
`include "csp_consts.svh"

module csp_serial_port #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Serial link
	input  wire logic              sclk,
	input  wire logic              din,
	input  wire logic              alternate_serial_input,
	input  wire logic              direct_config_input,
	input  wire logic              hw_secondary_request,
	input  wire logic [1:0]        master_mode_select,
	output logic                   frame_sync_n,
	output logic                   dout,
	// Converter side
	input  wire logic [15:0]       adc_data,
	output logic                   adc_take,
	output logic [15:0]            dac_data,
	output logic                   dac_valid
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	localparam int NPIN = 7;
	logic [NPIN-1:0] pin_in;
	logic [NPIN-1:0] pin_s1_r;
	logic [NPIN-1:0] pin_s2_r;
	logic            sclk_d_r;
	logic            req_d_r;

	assign pin_in = {master_mode_select, hw_secondary_request, direct_config_input,
		alternate_serial_input, din, sclk};

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					pin_s1_r[gi] <= 1'b0;
					pin_s2_r[gi] <= 1'b0;
				end else begin
					pin_s1_r[gi] <= pin_in[gi];
					pin_s2_r[gi] <= pin_s1_r[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sclk_d_r <= 1'b0;
			req_d_r  <= 1'b0;
		end else begin
			sclk_d_r <= pin_s2_r[0];
			req_d_r  <= pin_s2_r[4];
		end
	end

	logic       sclk_rise;
	logic       sclk_fall;
	logic       req_rise;
	logic [1:0] mms;
	assign sclk_rise = pin_s2_r[0] & ~sclk_d_r;
	assign sclk_fall = ~pin_s2_r[0] & sclk_d_r;
	assign req_rise  = pin_s2_r[4] & ~req_d_r;
	assign mms       = pin_s2_r[6:5];

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	logic              aw_have_r, aw_have_nxt;
	logic              w_have_r, w_have_nxt;
	logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
	logic [7:0]        w_byte_r, w_byte_nxt;
	logic              w_lane_r, w_lane_nxt;
	logic              bvalid_r, bvalid_nxt;
	logic [1:0]        bresp_r, bresp_nxt;
	logic              rvalid_r, rvalid_nxt;
	logic [1:0]        rresp_r, rresp_nxt;
	logic [31:0]       rdata_r, rdata_nxt;
	logic              axi_wr;
	logic [31:0]       rd_val;

	logic [7:0]        cfg_r, cfg_nxt;
	logic [7:0]        creg_r [1:4];
	logic [7:0]        creg_nxt [1:4];
	logic [4:1]        rdm_r, rdm_nxt;
	logic              sec_pend_r, sec_pend_nxt;
	logic [15:0]       dac_r, dac_nxt;
	logic              cont;
	logic              mode16;

	function automatic logic is_creg(input logic [ADDR_W-1:0] a);
		is_creg = (a >= ADDR_W'(`CSP_OFF_CREG_BASE)) && (a <= ADDR_W'(`CSP_OFF_CREG_LAST))
			&& (a[1:0] == 2'h0);
	endfunction

	function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
		addr_ok = is_creg(a) || (a == ADDR_W'(`CSP_OFF_CONFIG))
			|| (a == ADDR_W'(`CSP_OFF_STATUS)) || (a == ADDR_W'(`CSP_OFF_DAC));
	endfunction

	function automatic logic [2:0] creg_idx(input logic [ADDR_W-1:0] a);
		creg_idx = {1'b0, a[3:2]} + 3'h1;
	endfunction

	assign s_axi_awready = ~aw_have_r;
	assign s_axi_wready  = ~w_have_r;
	assign s_axi_arready = ~rvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rresp   = rresp_r;
	assign s_axi_rdata   = rdata_r;
	assign axi_wr        = aw_have_r & w_have_r & ~bvalid_r;

	always_comb begin
		rd_val = 32'h0000_0000;
		if (s_axi_araddr == ADDR_W'(`CSP_OFF_CONFIG)) begin
			rd_val = {24'h00_0000, cfg_r};
		end else if (s_axi_araddr == ADDR_W'(`CSP_OFF_STATUS)) begin
			rd_val = {24'h00_0000, rdm_r, 1'b0, mode16, cont, sec_pend_r};
		end else if (s_axi_araddr == ADDR_W'(`CSP_OFF_DAC)) begin
			rd_val = {16'h0000, dac_r};
		end else if (is_creg(s_axi_araddr)) begin
			rd_val = {24'h00_0000, creg_r[creg_idx(s_axi_araddr)]};
		end
	end

	always_comb begin
		aw_have_nxt = aw_have_r;
		w_have_nxt  = w_have_r;
		aw_addr_nxt = aw_addr_r;
		w_byte_nxt  = w_byte_r;
		w_lane_nxt  = w_lane_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		rvalid_nxt  = rvalid_r;
		rresp_nxt   = rresp_r;
		rdata_nxt   = rdata_r;
		if (s_axi_awvalid && !aw_have_r) begin
			aw_have_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_have_r) begin
			w_have_nxt = 1'b1;
			w_byte_nxt = s_axi_wdata[7:0];
			w_lane_nxt = s_axi_wstrb[0];
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (axi_wr) begin
			aw_have_nxt = 1'b0;
			w_have_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = addr_ok(aw_addr_r) ? `CSP_RESP_OKAY : `CSP_RESP_SLVERR;
		end
		if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && !rvalid_r) begin
			rvalid_nxt = 1'b1;
			rdata_nxt  = rd_val;
			rresp_nxt  = addr_ok(s_axi_araddr) ? `CSP_RESP_OKAY : `CSP_RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			aw_addr_r <= '0;
			w_byte_r  <= 8'h00;
			w_lane_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `CSP_RESP_OKAY;
			rvalid_r  <= 1'b0;
			rresp_r   <= `CSP_RESP_OKAY;
			rdata_r   <= 32'h0000_0000;
		end else begin
			aw_have_r <= aw_have_nxt;
			w_have_r  <= w_have_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_byte_r  <= w_byte_nxt;
			w_lane_r  <= w_lane_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			rvalid_r  <= rvalid_nxt;
			rresp_r   <= rresp_nxt;
			rdata_r   <= rdata_nxt;
		end
	end

	// ----------------------------------------
	// Frame engine and control registers
	// ----------------------------------------
	logic [9:0]                  slot_r, slot_nxt;
	logic                        fs_r, fs_nxt;
	logic                        act_r, act_nxt;
	logic                        sec_r, sec_nxt;
	logic [3:0]                  bit_r, bit_nxt;
	logic [15:0]                 rx_r, rx_nxt;
	logic [15:0]                 txs_r, txs_nxt;
	logic                        dout_r, dout_nxt;
	logic                        take_r, take_nxt;
	logic                        dval_r, dval_nxt;
	csp_pkg::csp_dci_state_t     dci_r, dci_nxt;
	logic [3:0]                  dcnt_r, dcnt_nxt;
	logic [14:0]                 dsh_r, dsh_nxt;
	logic [9:0]                  period;
	logic [2:0]                  own;
	logic [7:0]                  rd_byte;
	logic [15:0]                 sec_tx;
	logic [15:0]                 w;
	logic [14:0]                 dw;

	function automatic logic reg_ok(input logic [2:0] ra);
		reg_ok = (ra != 3'h0) && (ra <= `CSP_NUM_CREG);
	endfunction

	assign own    = cfg_r[2:0];
	assign mode16 = creg_r[1][`CSP_CR1_WORD16];
	assign cont   = creg_r[3][`CSP_CR3_CONT] & cfg_r[`CSP_CFG_SOLO_BIT]
		& (mms == 2'h0);
	assign period = cont ? `CSP_PERIOD_CONT
		: (cfg_r[`CSP_CFG_BIG_BIT] ? `CSP_PERIOD_BIG : `CSP_PERIOD_STD);
	assign rd_byte = (rx_r[7:5] == own && rx_r[4] && reg_ok(rx_r[3:1]))
		? creg_r[rx_r[3:1]] : 8'h00;
	assign sec_tx = {own, 5'h00, rd_byte};

	always_comb begin
		slot_nxt     = slot_r;
		fs_nxt       = fs_r;
		act_nxt      = act_r;
		sec_nxt      = sec_r;
		bit_nxt      = bit_r;
		rx_nxt       = rx_r;
		txs_nxt      = txs_r;
		dout_nxt     = dout_r;
		take_nxt     = 1'b0;
		dval_nxt     = 1'b0;
		dac_nxt      = dac_r;
		cfg_nxt      = cfg_r;
		creg_nxt     = creg_r;
		rdm_nxt      = rdm_r;
		sec_pend_nxt = sec_pend_r;
		dci_nxt      = dci_r;
		dcnt_nxt     = dcnt_r;
		dsh_nxt      = dsh_r;
		w            = {rx_r[14:0], pin_s2_r[1]};
		dw           = {dsh_r[13:0], pin_s2_r[3]};
		if (axi_wr && w_lane_r) begin
			if (aw_addr_r == ADDR_W'(`CSP_OFF_CONFIG)) begin
				cfg_nxt = w_byte_r;
			end else if (is_creg(aw_addr_r)) begin
				creg_nxt[creg_idx(aw_addr_r)] = w_byte_r;
			end
		end
		if (sclk_rise) begin
			slot_nxt = (slot_r >= period - 10'h001) ? 10'h000 : slot_r + 10'h001;
			fs_nxt = !((slot_nxt == 10'h000) || (!cont && sec_pend_r
				&& slot_nxt == (period >> 1)));
			if (!fs_r) begin
				act_nxt  = 1'b1;
				sec_nxt  = (slot_r != 10'h000);
				bit_nxt  = `CSP_WORD_MSB;
				txs_nxt  = adc_data;
				take_nxt = (slot_r == 10'h000);
				dout_nxt = sec_nxt ? sec_tx[`CSP_WORD_MSB] : adc_data[`CSP_WORD_MSB];
			end else if (act_r && bit_r != 4'h0) begin
				bit_nxt  = bit_r - 4'h1;
				// Freeze answer once the header is in
				if (sec_r && bit_nxt == 4'h7) begin
					txs_nxt = sec_tx;
				end
				dout_nxt = (sec_r && bit_nxt > 4'h7) ? sec_tx[bit_nxt]
					: txs_nxt[bit_nxt];
			end else begin
				act_nxt  = 1'b0;
				dout_nxt = 1'b0;
			end
		end
		if (sclk_fall && act_r) begin
			if (sec_r && cfg_r[`CSP_CFG_ALT_BIT]) begin
				w[0] = pin_s2_r[2];
			end
			rx_nxt = w;
			if (bit_r == 4'h0 && !sec_r) begin
				dval_nxt = 1'b1;
				dac_nxt  = mode16 ? w : {w[15:1], 1'b0};
				if (!mode16 && !cont && w[0]) begin
					sec_pend_nxt = 1'b1;
				end
			end else if (bit_r == 4'h0) begin
				sec_pend_nxt = 1'b0;
				if (w[15:13] == own && w[15:8] != 8'h00 && reg_ok(w[11:9])) begin
					if (w[12]) begin
						rdm_nxt[w[11:9]] = 1'b1;
					end else if (rdm_r[w[11:9]]) begin
						rdm_nxt[w[11:9]] = 1'b0;
					end else begin
						creg_nxt[w[11:9]] = w[7:0];
					end
				end
			end
		end
		if (req_rise && !cont) begin
			sec_pend_nxt = 1'b1;
		end
		if (sclk_fall) begin
			case (dci_r)
				csp_pkg::DCI_IDLE: begin
					if (!pin_s2_r[3]) begin
						dci_nxt  = csp_pkg::DCI_SHIFT;
						dcnt_nxt = `CSP_DCI_BITS;
					end
				end
				csp_pkg::DCI_SHIFT: begin
					dsh_nxt  = dw;
					dcnt_nxt = dcnt_r - 4'h1;
					if (dcnt_r == 4'h0) begin
						dci_nxt = csp_pkg::DCI_STOP;
						if (dw[14:12] == own && reg_ok(dw[11:9])) begin
							creg_nxt[dw[11:9]] = dw[7:0];
						end
					end
				end
				csp_pkg::DCI_STOP: begin
					if (pin_s2_r[3]) begin
						dci_nxt = csp_pkg::DCI_IDLE;
					end
				end
				default: begin
					dci_nxt = csp_pkg::DCI_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slot_r     <= 10'h000;
			fs_r       <= 1'b1;
			act_r      <= 1'b0;
			sec_r      <= 1'b0;
			bit_r      <= 4'h0;
			rx_r       <= 16'h0000;
			txs_r      <= 16'h0000;
			dout_r     <= 1'b0;
			take_r     <= 1'b0;
			dval_r     <= 1'b0;
			dac_r      <= 16'h0000;
			cfg_r      <= `CSP_CFG_RST;
			creg_r     <= '{default: `CSP_CREG_RST};
			rdm_r      <= 4'h0;
			sec_pend_r <= 1'b0;
			dci_r      <= csp_pkg::DCI_IDLE;
			dcnt_r     <= 4'h0;
			dsh_r      <= 15'h0000;
		end else begin
			slot_r     <= slot_nxt;
			fs_r       <= fs_nxt;
			act_r      <= act_nxt;
			sec_r      <= sec_nxt;
			bit_r      <= bit_nxt;
			rx_r       <= rx_nxt;
			txs_r      <= txs_nxt;
			dout_r     <= dout_nxt;
			take_r     <= take_nxt;
			dval_r     <= dval_nxt;
			dac_r      <= dac_nxt;
			cfg_r      <= cfg_nxt;
			creg_r     <= creg_nxt;
			rdm_r      <= rdm_nxt;
			sec_pend_r <= sec_pend_nxt;
			dci_r      <= dci_nxt;
			dcnt_r     <= dcnt_nxt;
			dsh_r      <= dsh_nxt;
		end
	end

	assign frame_sync_n = fs_r;
	assign dout         = dout_r;
	assign adc_take     = take_r;
	assign dac_data     = dac_r;
	assign dac_valid    = dval_r;

endmodule

//--- rtl/csp_consts.svh
/*
 * Offsets, field positions, reset values and frame counts of the codec serial control port.
 * Assumes inclusion by bare name from the design files only.
 */
`ifndef CSP_CONSTS_SVH
`define CSP_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CSP_OFF_CONFIG    12'h000
`define CSP_OFF_STATUS    12'h004
`define CSP_OFF_DAC       12'h008
`define CSP_OFF_CREG_BASE 12'h010
`define CSP_OFF_CREG_LAST 12'h01C

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CSP_CFG_ALT_BIT   3
`define CSP_CFG_BIG_BIT   4
`define CSP_CFG_SOLO_BIT  5
`define CSP_CFG_RST       8'h20
`define CSP_CREG_RST      8'h00
`define CSP_CR1_WORD16    0
`define CSP_CR3_CONT      5
`define CSP_NUM_CREG      3'h4

// ----------------------------------------
// Frame counts in bit clocks
// ----------------------------------------
`define CSP_PERIOD_STD    10'h100
`define CSP_PERIOD_BIG    10'h200
`define CSP_PERIOD_CONT   10'h010
`define CSP_WORD_MSB      4'hF
`define CSP_DCI_BITS      4'hE

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define CSP_RESP_OKAY     2'h0
`define CSP_RESP_SLVERR   2'h2

`endif

//--- rtl/csp_pkg.sv
/*
 * Types of the codec serial control port.
 * Assumes nothing of its surroundings.
 */
package csp_pkg;

	typedef enum logic [1:0] {
		DCI_IDLE,
		DCI_SHIFT,
		DCI_STOP
	} csp_dci_state_t;

endpackage

//--- test/csp_serial_port_props.sv
/* Checker of the codec serial port, watching only its ports.
 * Assumes binding into every csp_serial_port instance. */
`timescale 1ns/10ps
module csp_serial_port_props #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input wire logic              aclk,
	input wire logic              aresetn,
	// Register bus
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	// Link and converter
	input wire logic              frame_sync_n,
	input wire logic              dout,
	input wire logic [15:0]       adc_data,
	input wire logic              adc_take,
	input wire logic [15:0]       dac_data,
	input wire logic              dac_valid
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
		else $error("read not answered");
	a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 12'h01C
		|-> ##[1:2] (s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000))
		else $error("unmapped read not refused");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##1 (!s_axi_awready && !s_axi_wready) ##1 s_axi_bvalid)
		else $error("write not answered");
	a_bus_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
		&& s_axi_awready) else $error("write response not released");
	a_sync_slot: assert property ($fell(frame_sync_n) |-> !frame_sync_n [*8] ##[16:20]
		frame_sync_n) else $error("frame sync not one slot");
	a_dac_pulse: assert property (dac_valid |=> !dac_valid)
		else $error("dac valid longer than one cycle");
	a_dac_steady: assert property ($changed(dac_data) |-> dac_valid)
		else $error("dac data changed without valid");
	a_take_pulse: assert property (adc_take |=> !adc_take)
		else $error("adc take longer than one cycle");
	a_take_msb: assert property ($rose(adc_take) |-> ##[0:3] dout == adc_data[15])
		else $error("first bit out is not the sample msb");
endmodule

bind csp_serial_port csp_serial_port_props #(.ADDR_W(ADDR_W)) i_csp_serial_port_props (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .frame_sync_n(frame_sync_n),
	.dout(dout), .adc_data(adc_data), .adc_take(adc_take), .dac_data(dac_data),
	.dac_valid(dac_valid)
);

//--- test/csp_host_model.sv
/* Host serial port model: free bit clock, din words after each frame sync,
 * dout capture, request pulses and direct configuration words.
 * Assumes the codec drives frame_sync_n and dout from its own clock. */
`timescale 1ns/10ps
module csp_host_model (
	// Link lines
	output logic      sclk,
	output logic      din,
	output logic      direct_config_input,
	output logic      hw_secondary_request,
	// Codec outputs
	input  wire logic frame_sync_n,
	input  wire logic dout
);
	logic [15:0] tx_prim = 16'h0000;
	logic [15:0] tx_sec  = 16'h0000;
	logic [15:0] tx_sh   = 16'h0000;
	logic [15:0] tx_next = 16'h0000;
	logic        tx_go   = 1'b0;
	logic        tx_ack  = 1'b0;
	logic [15:0] rx_sh   = 16'h0000;
	logic [15:0] rx_word = 16'h0000;
	logic        rx_sec  = 1'b0;
	logic        cur_sec = 1'b0;
	int          tx_n    = 0;
	int          rx_n    = 0;
	int          slot    = 0;
	int          gap     = 0;
	int          words   = 0;

	initial begin
		sclk = 1'b0;
		din = 1'b0;
		direct_config_input = 1'b1;
		hw_secondary_request = 1'b0;
	end

	always #62.5 sclk = ~sclk;

	// Frame start and dout capture, msb first
	always @(negedge sclk) begin
		slot <= slot + 1;
		if (rx_n > 0) begin
			rx_sh <= {rx_sh[14:0], dout};
			rx_n <= rx_n - 1;
		end
		if (rx_n == 1) begin
			rx_word <= {rx_sh[14:0], dout};
			rx_sec <= cur_sec;
			words <= words + 1;
		end
		if (frame_sync_n == 1'b0) begin
			gap <= slot;
			slot <= 1;
			cur_sec <= (slot == 128) && !cur_sec;
			tx_next <= ((slot == 128) && !cur_sec) ? tx_sec : tx_prim;
			tx_go <= ~tx_go;
			rx_n <= 16;
		end
	end

	// Word on din, msb first; released line toggles
	always @(posedge sclk) begin
		if (tx_go != tx_ack) begin
			tx_ack <= tx_go;
			din <= tx_next[15];
			tx_sh <= {tx_next[14:0], 1'b0};
			tx_n <= 15;
		end else if (tx_n > 0) begin
			din <= tx_sh[15];
			tx_sh <= {tx_sh[14:0], 1'b0};
			tx_n <= tx_n - 1;
		end else
			din <= ~din;
	end

	// One pulse per requested secondary frame
	task automatic pulse_req();
		@(posedge sclk);
		hw_secondary_request <= 1'b1;
		repeat (2) @(posedge sclk);
		hw_secondary_request <= 1'b0;
	endtask

	// Start bit in w[15], then fields, then stop bit and idle high
	task automatic send_cfg(input logic [15:0] w);
		for (int i = 15; i >= 0; i--) begin
			@(posedge sclk);
			direct_config_input <= w[i];
		end
		@(posedge sclk);
		direct_config_input <= 1'b1;
	endtask
endmodule

//--- test/csp_serial_port_tb.sv
/* Bench of the codec serial port: AXI4-Lite master tasks and frame scenarios.
 * Assumes the host model drives the link pins and the checker is bound. */
`timescale 1ns/10ps
module csp_serial_port_tb;
	logic        aclk     = 1'b0;
	logic        aresetn  = 1'b0;
	logic [11:0] awaddr   = 12'h000;
	logic [11:0] araddr   = 12'h000;
	logic [31:0] wdata    = 32'h0000_0000;
	logic        awvalid  = 1'b0;
	logic        wvalid   = 1'b0;
	logic        bready   = 1'b0;
	logic        arvalid  = 1'b0;
	logic        rready   = 1'b0;
	logic [15:0] adc_data = 16'hA5C3;
	logic [1:0]  mode_sel = 2'b00;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        sclk, din, dci, hw_req, fs_n, dout, adc_take, dac_valid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] dac_data;
	int          miscompares = 0;
	int          comparisons = 0;
	int          cycles      = 0;

	always #2.5 aclk = ~aclk;

	csp_serial_port i_csp_serial_port (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sclk(sclk), .din(din), .alternate_serial_input(1'b1), .direct_config_input(dci),
		.hw_secondary_request(hw_req), .master_mode_select(mode_sel),
		.frame_sync_n(fs_n), .dout(dout), .adc_data(adc_data), .adc_take(adc_take),
		.dac_data(dac_data), .dac_valid(dac_valid)
	);

	csp_host_model i_csp_host_model (
		.sclk(sclk), .din(din), .direct_config_input(dci), .hw_secondary_request(hw_req),
		.frame_sync_n(fs_n), .dout(dout)
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic report_and_stop();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 95000) begin
			miscompares++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0000_00, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1)
				awvalid <= 1'b0;
			if (wvalid && wready === 1'b1)
				wvalid <= 1'b0;
			if (bready && bvalid === 1'b1) begin
				bready <= 1'b0;
				chk(32'(bresp), 32'(er));
			end
		end while (awvalid || wvalid || bready);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready === 1'b1)
				arvalid <= 1'b0;
			if (rready && rvalid === 1'b1) begin
				rready <= 1'b0;
				chk(rdata, e);
				chk(32'(rresp), 32'(er));
			end
		end while (arvalid || rready);
	endtask

	task automatic get_word();
		int n;
		n = i_csp_host_model.words;
		while (i_csp_host_model.words == n)
			@(posedge aclk);
		repeat (8) @(posedge aclk);
	endtask

	task automatic sec_xfer(input logic [15:0] w, input logic hw);
		i_csp_host_model.tx_sec = w;
		i_csp_host_model.tx_prim = hw ? 16'h1234 : 16'h1235;
		get_word();
		i_csp_host_model.tx_prim = 16'h1234;
		if (hw)
			i_csp_host_model.pulse_req();
		get_word();
		chk(32'(i_csp_host_model.rx_sec), 32'h0000_0001);
		chk(32'(i_csp_host_model.gap), 32'h0000_0080);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd(12'h000, 32'h0000_0020, 2'h0);
		for (int i = 0; i < 4; i++)
			rd(12'h010 + 12'(4 * i), 32'h0000_0000, 2'h0);
		rd(12'h020, 32'h0000_0000, 2'h2);
		wr(12'h024, 8'h55, 2'h2);
		wr(12'h000, 8'h23, 2'h0);
		rd(12'h000, 32'h0000_0023, 2'h0);
	endtask

	task automatic t_primary();
		get_word();
		chk(32'(i_csp_host_model.rx_word), 32'h0000_A5C3);
		chk(32'(dac_data), 32'h0000_B6A8);
	endtask

	task automatic t_sec_write();
		sec_xfer(16'h645A, 1'b0);
		chk(32'(i_csp_host_model.rx_word), 32'h0000_6000);
		chk(32'(dac_data), 32'h0000_1234);
		rd(12'h014, 32'h0000_005A, 2'h0);
	endtask

	task automatic t_sec_read();
		sec_xfer(16'h7400, 1'b1);
		chk(32'(i_csp_host_model.rx_word), 32'h0000_605A);
		rd(12'h004, 32'h0000_0020, 2'h0);
		sec_xfer(16'h6411, 1'b0);
		rd(12'h004, 32'h0000_0000, 2'h0);
		rd(12'h014, 32'h0000_005A, 2'h0);
	endtask

	task automatic t_ignored();
		sec_xfer(16'h00FF, 1'b0);
		sec_xfer(16'hA2EE, 1'b0);
		rd(12'h014, 32'h0000_005A, 2'h0);
		rd(12'h010, 32'h0000_0000, 2'h0);
		wr(12'h000, 8'h2B, 2'h0);
		sec_xfer(16'h6433, 1'b0);
		wr(12'h000, 8'h23, 2'h0);
		rd(12'h014, 32'h0000_005A, 2'h0);
	endtask

	task automatic t_word16();
		wr(12'h010, 8'h01, 2'h0);
		i_csp_host_model.tx_prim = 16'hB6A9;
		get_word();
		i_csp_host_model.tx_prim = 16'h0000;
		chk(32'(dac_data), 32'h0000_B6A9);
		get_word();
		chk(32'(i_csp_host_model.rx_sec), 32'h0000_0000);
		chk(32'(i_csp_host_model.gap), 32'h0000_0100);
	endtask

	task automatic t_continuous();
		wr(12'h018, 8'h20, 2'h0);
		repeat (3) get_word();
		chk(32'(i_csp_host_model.gap), 32'h0000_0010);
		chk(32'(i_csp_host_model.rx_word), 32'h0000_A5C3);
		rd(12'h004, 32'h0000_0006, 2'h0);
		i_csp_host_model.pulse_req();
		i_csp_host_model.send_cfg(16'h38C3);
		rd(12'h01C, 32'h0000_00C3, 2'h0);
		get_word();
		chk(32'(i_csp_host_model.rx_sec), 32'h0000_0000);
		rd(12'h004, 32'h0000_0006, 2'h0);
		mode_sel <= 2'b01;
		repeat (8) @(posedge aclk);
		rd(12'h004, 32'h0000_0004, 2'h0);
	endtask

	initial begin
		i_csp_host_model.tx_prim = 16'hB6A8;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_primary();
		t_sec_write();
		t_sec_read();
		t_ignored();
		t_word16();
		t_continuous();
		report_and_stop();
	end
endmodule
